// [ifad_consts.svh]
// Purpose: Shared constants for the interleaved flash converter output path.
// Assumes: One ref_clk edge stands for one falling edge of the converter input clock.
// Notes:   Offsets and counts are macros; types live in ifad_pkg.
//
// How it works
// RL1 - Thermometer of 255 comparators decodes to count of ones minus one.
// RL2 - Comparators follow input while their clock is low, hold while high.
// RL3 - Halves deliver words alternately to first and second port latches.
// RL4 - Normal mode output data clock runs at half the input clock.
// RL5 - First port valid after clock rise, second port after clock fall.
// RL6 - Grounded selector divides clock by ten, keeps one of five samples.
// RL7 - Output data clock keeps fifty percent duty in both modes.
// RL8 - Undriven selector leaves the device in normal mode.
// RL9 - Converted value appears at the ports 15 clock cycles after sampling.
// RL10 - Over-range gives all ones, under-range all zeros, mid gives 10000000.
// RL11 - Input clock divided by two forms the conversion strobes.
// RL12 - Negative strobe edge puts one half into hold for its comparators.
// RL13 - Without tracking, the output phase after start-up is arbitrary; here reset loads the strobe low, so the phase after reset is fixed.
// RL14 - Tracking input high before a falling edge selects the first port.
// RL15 - Capture logic rebuilds samples taking first then second port words.
`ifndef IFAD_CONSTS_SVH
`define IFAD_CONSTS_SVH

// ==========================================================================
// Converter geometry
`define IFAD_BITS          8
`define IFAD_COMPARATORS   255
`define IFAD_CODE_FULL     8'hFF
`define IFAD_CODE_ZERO     8'h00

// ==========================================================================
// Timing counts
`define IFAD_LATENCY       15
`define IFAD_FIXED_STAGES  1
`define IFAD_DIV_NORMAL    2
`define IFAD_DIV_TEST      10
`define IFAD_CNT_W         4

`endif

// [ifad_pkg.sv]
// Purpose: Types for the interleaved flash converter output path.
// Assumes: Constants come from ifad_consts.svh.
// Notes:   None.
package ifad_pkg;

  typedef enum logic {
    IFAD_MODE_NORMAL,
    IFAD_MODE_TEST
  } ifad_mode_t;

  typedef enum logic [1:0] {
    IFAD_ODC_ALIGN,
    IFAD_ODC_RUN
  } ifad_odc_state_t;

endpackage : ifad_pkg

// [ifad_comparator_bank.sv]
// Purpose: Latched comparator bank of one converter half.
// Assumes: comp_clk is a level from the strobe divider.
// Notes:   Follows while comp_clk is low, holds while high.
`timescale 1ns/1ps
`include "ifad_consts.svh"
module ifad_comparator_bank #(
  parameter int COMPARATORS = `IFAD_COMPARATORS
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   comp_clk,
  input  wire logic [COMPARATORS-1:0] thermo_in,
  output logic      [COMPARATORS-1:0] latched
);
  import ifad_pkg::*;

  initial begin
    if (COMPARATORS < 1) begin
      $error("COMPARATORS must be at least one.");
    end
  end

  // ==========================================================================
  // Latch
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      latched <= '0;
    end else if (!comp_clk) begin
      latched <= thermo_in; // [RL2]
    end
  end

endmodule : ifad_comparator_bank

// [ifad_thermo_decode.sv]
// Purpose: Thermometer to binary decode with end-of-range clamping.
// Assumes: Bubbles are tolerated by counting ones.
// Notes:   Purely combinational.
`timescale 1ns/1ps
`include "ifad_consts.svh"
module ifad_thermo_decode #(
  parameter int BITS        = `IFAD_BITS,
  parameter int COMPARATORS = `IFAD_COMPARATORS
) (
  input  wire logic [COMPARATORS-1:0] thermo,
  output logic      [BITS-1:0]        code
);
  import ifad_pkg::*;

  initial begin
    if (COMPARATORS != (2 ** BITS) - 1) begin
      $error("COMPARATORS must equal two to the BITS minus one.");
    end
  end

  // Counts the comparators whose threshold lies below the input.
  function automatic logic [BITS:0] count_ones(input logic [COMPARATORS-1:0] t);
    logic [BITS:0] n;
    n = '0;
    for (int i = 0; i < COMPARATORS; i++) begin
      n = n + {{BITS{1'b0}}, t[i]};
    end
    return n;
  endfunction : count_ones

  logic [BITS:0] ones;

  // ==========================================================================
  // Decode
  always_comb begin
    ones = count_ones(thermo);
    if (ones == (BITS+1)'(COMPARATORS)) begin
      code = {BITS{1'b1}}; // [RL10]
    end else if (ones == '0) begin
      code = '0; // [RL10]
    end else begin
      code = BITS'(ones - 1'b1); // [RL1]
    end
  end

endmodule : ifad_thermo_decode

// [ifad_output_timing.sv]
// Purpose: Strobe division, interleave, pipeline and output clocking of the
//          dual flash converter.
// Assumes: Each ref_clk edge is one falling edge of the input clock.
// Notes:   The selector pin is modelled as a drive flag plus a level.
`timescale 1ns/1ps
`include "ifad_consts.svh"
module ifad_output_timing #(
  parameter int BITS        = `IFAD_BITS,
  parameter int COMPARATORS = `IFAD_COMPARATORS,
  parameter int LATENCY     = `IFAD_LATENCY
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic [COMPARATORS-1:0] thermo_first,
  input  wire logic [COMPARATORS-1:0] thermo_second,
  input  wire logic                   test_divide_select_driven,
  input  wire logic                   test_divide_select,
  input  wire logic                   phase_track_enable,
  input  wire logic                   phase_track_input,
  output logic                        output_data_clock,
  output logic      [BITS-1:0]        first_port_data,
  output logic      [BITS-1:0]        second_port_data,
  output logic                        strobe_first_hold,
  output ifad_pkg::ifad_mode_t        output_mode
);
  import ifad_pkg::*;

  localparam int DELAY = LATENCY - `IFAD_FIXED_STAGES;

  initial begin
    if (LATENCY < `IFAD_FIXED_STAGES + 1) begin
      $error("LATENCY is too small for the fixed stages.");
    end
  end

  // ==========================================================================
  // Mode selection
  ifad_mode_t mode_next;
  ifad_mode_t mode_reg;

  always_comb begin
    if (test_divide_select_driven && !test_divide_select) begin
      mode_next = IFAD_MODE_TEST; // [RL6]
    end else begin
      mode_next = IFAD_MODE_NORMAL; // [RL8]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_reg <= IFAD_MODE_NORMAL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign output_mode = mode_reg;

  // ==========================================================================
  // Strobe divider
  logic strobe_reg;
  logic strobe_next;

  always_comb begin
    if (phase_track_enable) begin
      strobe_next = phase_track_input; // [RL14]
    end else begin
      strobe_next = ~strobe_reg; // [RL11] [RL13]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      strobe_reg <= 1'b0;
    end else begin
      strobe_reg <= strobe_next;
    end
  end

  assign strobe_first_hold = ~strobe_reg;

  // ==========================================================================
  // Comparator halves
  logic [COMPARATORS-1:0] latched_first;
  logic [COMPARATORS-1:0] latched_second;
  logic [BITS-1:0]        code_first;
  logic [BITS-1:0]        code_second;

  // First half follows while strobe is low, its comparators latch when high.
  ifad_comparator_bank #(.COMPARATORS(COMPARATORS)) u_bank_first (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .comp_clk (strobe_reg),
    .thermo_in(thermo_first),
    .latched  (latched_first)
  ); // [RL12]

  ifad_comparator_bank #(.COMPARATORS(COMPARATORS)) u_bank_second (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .comp_clk (~strobe_reg),
    .thermo_in(thermo_second),
    .latched  (latched_second)
  ); // [RL12]

  ifad_thermo_decode #(.BITS(BITS), .COMPARATORS(COMPARATORS)) u_dec_first (
    .thermo(latched_first),
    .code  (code_first)
  );

  ifad_thermo_decode #(.BITS(BITS), .COMPARATORS(COMPARATORS)) u_dec_second (
    .thermo(latched_second),
    .code  (code_second)
  );

  // ==========================================================================
  // Interleaved pipeline
  logic [BITS-1:0] pipe_word_reg [DELAY];
  logic            pipe_tag_reg  [DELAY];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < DELAY; i++) begin
        pipe_word_reg[i] <= '0;
        pipe_tag_reg[i]  <= 1'b0;
      end
    end else begin
      pipe_word_reg[0] <= strobe_reg ? code_first : code_second; // [RL3]
      pipe_tag_reg[0]  <= strobe_reg;
      for (int i = 1; i < DELAY; i++) begin
        pipe_word_reg[i] <= pipe_word_reg[i-1]; // [RL9]
        pipe_tag_reg[i]  <= pipe_tag_reg[i-1];
      end
    end
  end

  logic [BITS-1:0] tail_word;
  logic            tail_first;

  assign tail_word  = pipe_word_reg[DELAY-1];
  assign tail_first = pipe_tag_reg[DELAY-1];

  // ==========================================================================
  // Output data clock divider
  ifad_odc_state_t       odc_state_reg;
  logic [`IFAD_CNT_W-1:0] div_cnt_reg;
  logic [`IFAD_CNT_W-1:0] div_last;
  logic [`IFAD_CNT_W-1:0] div_half;
  logic                  at_rise;
  logic                  at_fall;
  logic                  odc_reg;

  always_comb begin
    if (mode_reg == IFAD_MODE_TEST) begin
      div_last = `IFAD_CNT_W'(`IFAD_DIV_TEST - 1); // [RL6]
      div_half = `IFAD_CNT_W'(`IFAD_DIV_TEST / 2); // [RL7]
    end else begin
      div_last = `IFAD_CNT_W'(`IFAD_DIV_NORMAL - 1); // [RL4]
      div_half = `IFAD_CNT_W'(`IFAD_DIV_NORMAL / 2); // [RL7]
    end
    at_rise = (div_cnt_reg == '0) && tail_first && (mode_reg == mode_next);
    at_fall = (div_cnt_reg == div_half) && !tail_first && (mode_reg == mode_next);
  end

  always_ff @(posedge ref_clk) begin
    if (rst || (mode_reg != mode_next)) begin
      odc_state_reg <= IFAD_ODC_ALIGN;
      div_cnt_reg   <= '0;
    end else begin
      case (odc_state_reg)
        IFAD_ODC_ALIGN: begin
          if (at_rise) begin
            odc_state_reg <= IFAD_ODC_RUN;
            div_cnt_reg   <= `IFAD_CNT_W'(1);
          end
        end
        IFAD_ODC_RUN: begin
          if ((div_cnt_reg == '0) && !tail_first) begin
            odc_state_reg <= IFAD_ODC_ALIGN;
          end else if (div_cnt_reg == div_last) begin
            div_cnt_reg <= '0;
          end else begin
            div_cnt_reg <= div_cnt_reg + `IFAD_CNT_W'(1);
          end
        end
        default: begin
          odc_state_reg <= IFAD_ODC_ALIGN;
          div_cnt_reg   <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      odc_reg <= 1'b0;
    end else if (at_rise) begin
      odc_reg <= 1'b1; // [RL5] [RL7]
    end else if (at_fall) begin
      odc_reg <= 1'b0; // [RL5] [RL7]
    end
  end

  assign output_data_clock = odc_reg;

  // ==========================================================================
  // Output port latches
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      first_port_data <= '0;
    end else if (at_rise) begin
      first_port_data <= tail_word; // [RL3] [RL5] [RL9]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      second_port_data <= '0;
    end else if (at_fall) begin
      second_port_data <= tail_word; // [RL3] [RL5] [RL9]
    end
  end

endmodule : ifad_output_timing

// [ifad_output_timing_assertions.sv]
// Purpose: Port checks for the converter output timing block.
// Assumes: One clock domain, synchronous reset.
// Notes:   Bound to every instance.
`timescale 1ns/1ps
module ifad_checker (
  input wire logic                 ref_clk,
  input wire logic                 rst,
  input wire logic                 test_divide_select_driven,
  input wire logic                 test_divide_select,
  input wire logic                 phase_track_enable,
  input wire logic                 phase_track_input,
  input wire logic                 output_data_clock,
  input wire logic [7:0]           first_port_data,
  input wire logic [7:0]           second_port_data,
  input wire logic                 strobe_first_hold,
  input wire ifad_pkg::ifad_mode_t output_mode
);
  import ifad_pkg::*;
  // ====================
  // Clock, data, strobe and mode relations.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic tm;
  assign tm = (output_mode == IFAD_MODE_TEST);
  sequence s_run5(v);
    (output_data_clock == v) [*5] ##1 (output_data_clock != v);
  endsequence
  a_first_on_rise: assert property ($changed(first_port_data) |-> $rose(output_data_clock))
    else $error("First port changed off a clock rise.");
  a_second_on_fall: assert property ($changed(second_port_data) |-> $fell(output_data_clock))
    else $error("Second port changed off a clock fall.");
  a_strobe_toggle: assert property (!phase_track_enable |=> strobe_first_hold != $past(strobe_first_hold))
    else $error("Strobe did not toggle.");
  a_track_phase: assert property (phase_track_enable |=> strobe_first_hold == !$past(phase_track_input))
    else $error("Strobe ignored the tracking input.");
  a_mode_select: assert property (1'b1 |=> tm == $past(test_divide_select_driven && !test_divide_select))
    else $error("Output mode does not follow the selector.");
  a_normal_half: assert property ($rose(output_data_clock) && !tm |=> !output_data_clock || tm)
    else $error("Normal clock high longer than one cycle.");
  a_test_high: assert property ($rose(output_data_clock) && tm |-> s_run5(1'b1) or ##[1:5] !tm)
    else $error("Test clock high phase is not five cycles.");
  a_test_low: assert property ($fell(output_data_clock) && tm |-> s_run5(1'b0) or ##[1:5] !tm)
    else $error("Test clock low phase is not five cycles.");
endmodule : ifad_checker

bind ifad_output_timing ifad_checker i_chk (.ref_clk, .rst, .test_divide_select_driven,
  .test_divide_select, .phase_track_enable, .phase_track_input, .output_data_clock,
  .first_port_data, .second_port_data, .strobe_first_hold, .output_mode);

// [ifad_capture.sv]
// Purpose: Capture logic on the far side of the output ports.
// Assumes: Ports are read one ref_clk edge after their clock edge.
// Notes:   Counts completed first and second word pairs.
`timescale 1ns/1ps
module ifad_capture (
  input wire logic  ref_clk,
  input wire logic  rst,
  input wire logic  output_data_clock,
  input wire logic [7:0] first_port_data,
  input wire logic [7:0] second_port_data,
  output logic [7:0]     first_word,
  output logic [7:0]     second_word,
  output logic [15:0]    pair_count
);
  logic clk_prev;
  always_ff @(posedge ref_clk) begin
    clk_prev <= output_data_clock;
    if (rst) begin
      first_word  <= 8'h00;
      second_word <= 8'h00;
      pair_count  <= 16'h0000;
    end else if (output_data_clock && !clk_prev) begin
      first_word <= first_port_data;
    end else if (!output_data_clock && clk_prev) begin
      second_word <= second_port_data;
      pair_count  <= pair_count + 16'h0001;
    end
  end
endmodule : ifad_capture

// [interleaved_flash_adc_output_timing_bench.sv]
// Purpose: Self-checking bench for the converter output timing block.
// Assumes: Reset gives first half on the first port.
// Notes:   Decode rows first, then timing and mode cases.
`timescale 1ns/1ps
module interleaved_flash_adc_output_timing_bench;
  import ifad_pkg::*;
  logic ref_clk, rst, sel_drv, sel, trk_en, trk, odc, hold, trk_p;
  logic [254:0] th_a, th_b;
  logic [7:0]   pa, pb, cap_a, cap_b, gap;
  logic [15:0]  pairs;
  ifad_mode_t   mode;
  int n_mismatch = 0;
  int compares = 0;
  int rows_n[6] = '{0, 1, 2, 129, 254, 255};
  logic [7:0] rows_c[6] = '{8'h00, 8'h00, 8'h01, 8'h80, 8'hFD, 8'hFF};
  ifad_output_timing i_dut (.ref_clk, .rst, .thermo_first(th_a), .thermo_second(th_b),
    .test_divide_select_driven(sel_drv), .test_divide_select(sel),
    .phase_track_enable(trk_en), .phase_track_input(trk), .output_data_clock(odc),
    .first_port_data(pa), .second_port_data(pb), .strobe_first_hold(hold),
    .output_mode(mode));
  ifad_capture i_cap (.ref_clk, .rst, .output_data_clock(odc), .first_port_data(pa),
    .second_port_data(pb), .first_word(cap_a), .second_word(cap_b), .pair_count(pairs));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [254:0] therm(input int n);
    therm = (255'(1) << n) - 255'(1);
  endfunction : therm
  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic rise_gap(output logic [7:0] g);
    int k, s;
    logic p;
    s = 0;
    g = 8'h00;
    p = odc;
    for (k = 0; k < 60 && s < 2; k++) begin
      @(posedge ref_clk);
      if (s == 1) g++;
      if (odc === 1'b1 && p !== 1'b1) s++;
      p = odc;
    end
    if (s < 2) begin
      n_mismatch++;
      stop_test();
    end
  endtask : rise_gap
  task automatic edge_sync(input logic low_too);
    int k;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (odc !== 1'b1 && k < 40);
    while (low_too && odc !== 1'b0 && k < 40) begin
      @(negedge ref_clk);
      k++;
    end
    if (k >= 40) begin
      n_mismatch++;
      stop_test();
    end
    @(posedge ref_clk);
  endtask : edge_sync
  initial begin
    rst = 1'b1;
    sel_drv = 1'b0;
    sel = 1'b0;
    trk_en = 1'b0;
    trk = 1'b0;
    th_a = '0;
    th_b = '0;
    tick(20);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      th_a <= therm(rows_n[i]);
      th_b <= therm(rows_n[i]);
      tick(20);
      check(pa, rows_c[i]);
      check(pb, rows_c[i]);
      check(cap_a, rows_c[i]);
    end
    th_a <= therm(200);
    th_b <= therm(200);
    tick(13);
    check(pa, 8'hFF);
    tick(5);
    check(pa, 8'hC7);
    th_a <= therm(10);
    th_b <= therm(20);
    tick(20);
    check(pa, 8'h09);
    check(cap_b, 8'h13);
    rise_gap(gap);
    check(gap, 8'h02);
    edge_sync(1'b0);
    sel_drv <= 1'b1;
    tick(30);
    check(8'(mode), 8'(IFAD_MODE_TEST));
    rise_gap(gap);
    check(gap, 8'h0A);
    tick(40);
    check(pa, 8'h09);
    check(pb, 8'h13);
    edge_sync(1'b1);
    sel_drv <= 1'b0;
    tick(30);
    check(8'(mode), 8'(IFAD_MODE_NORMAL));
    rise_gap(gap);
    check(gap, 8'h02);
    @(negedge ref_clk);
    trk_p = hold;
    @(posedge ref_clk);
    trk <= ~trk_p;
    trk_en <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      tick(1);
      trk <= ~trk;
    end
    check(pa, 8'h09);
    check(pb, 8'h13);
    trk_en <= 1'b0;
    rst <= 1'b1;
    tick(2);
    check(pa, 8'h00);
    check({pb[6:0], odc}, 8'h00);
    rst <= 1'b0;
    tick(20);
    check(cap_a, 8'h09);
    stop_test();
  end
endmodule : interleaved_flash_adc_output_timing_bench
